// ### logic/cods_top.sv
/*
  Power-down and edge-rate control for two serial cable driver outputs,
  with its two registers reached from the serial control port decoder.
  Assumes the decoder presents one-cycle wr/rd strobes synchronous to
  core_clk_i, and that the automatic power-down criteria are evaluated
  elsewhere and arrive as a level per output.
*/
`default_nettype none
`include "cods_cfg.svh"

module cods_top
  import cods_pkg::*;
#(
  parameter int ADDR_W = `CODS_ADDR_W,
  parameter int DATA_W = `CODS_DATA_W
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Register port from the serial control decoder
  input wire cods_req_t req_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  // Recovery loop status and automatic power-down requests
  input wire cods_cdr_t cdr_i,
  input wire logic [1:0] auto_power_down_req_i,
  // Cable driver controls
  output logic line_out_zero_power_down_o,
  output logic line_out_one_power_down_o,
  output cods_edge_t line_out_zero_edge_o,
  output cods_edge_t line_out_one_edge_o
);

  logic [DATA_W-1:0] pwr_q;
  logic [DATA_W-1:0] pwr_d;
  logic [DATA_W-1:0] edge_q;
  logic [DATA_W-1:0] edge_d;

  // Address decode
  wire logic hit_pwr = (req_i.addr == ADDR_W'(`CODS_OFS_POWER_DOWN));
  wire logic hit_edge = (req_i.addr == ADDR_W'(`CODS_OFS_EDGE_RATE));

  // Reserved bits are stored as written so a read-modify-write returns them intact
  assign pwr_d = (req_i.wr && hit_pwr) ? req_i.wdata : pwr_q;
  assign edge_d = (req_i.wr && hit_edge) ? req_i.wdata : edge_q;

  // Read mux; unmapped addresses read as zero
  wire logic [DATA_W-1:0] rd_mux = hit_pwr ? pwr_q : (hit_edge ? edge_q : '0);

  // Field extraction
  wire logic out0_auto_power_down_sel = pwr_q[`CODS_PD_OUT0_AUTO_BIT];
  wire logic out0_manual_power_down = pwr_q[`CODS_PD_OUT0_MAN_BIT];
  wire logic out1_auto_power_down_sel = pwr_q[`CODS_PD_OUT1_AUTO_BIT];
  wire logic out1_manual_power_down = pwr_q[`CODS_PD_OUT1_MAN_BIT];
  wire logic out0_auto_edge_sel = edge_q[`CODS_ER_OUT0_AUTO_BIT];
  wire logic [1:0] out0_manual_edge_class = edge_q[`CODS_ER_OUT0_MAN_LSB +: 2];
  wire logic out1_auto_edge_sel = edge_q[`CODS_ER_OUT1_AUTO_BIT];
  wire logic [1:0] out1_manual_edge_class = edge_q[`CODS_ER_OUT1_MAN_LSB +: 2];

  // Power-down selection: the manual bit is ignored while automatic is chosen
  wire logic pd0_d = out0_auto_power_down_sel ? auto_power_down_req_i[0]
                                              : out0_manual_power_down;
  wire logic pd1_d = out1_auto_power_down_sel ? auto_power_down_req_i[1]
                                              : out1_manual_power_down;

  // Class implied by the locked rate; an unlocked loop falls back to bypass
  wire cods_edge_t rate_edge = ((cdr_i.rate == CODS_RATE_125M) || (cdr_i.rate == CODS_RATE_270M))
                             ? CODS_EDGE_SD : CODS_EDGE_HD;
  wire cods_edge_t auto_edge = cdr_i.locked ? rate_edge : CODS_EDGE_BYPASS;

  // Undefined manual code 3 is folded to bypass so the driver never sees it
  wire cods_edge_t man0_edge = (out0_manual_edge_class == 2'h3) ? CODS_EDGE_BYPASS
                             : cods_edge_t'(out0_manual_edge_class);
  wire cods_edge_t man1_edge = (out1_manual_edge_class == 2'h3) ? CODS_EDGE_BYPASS
                             : cods_edge_t'(out1_manual_edge_class);
  wire cods_edge_t edge0_d = out0_auto_edge_sel ? auto_edge : man0_edge;
  wire cods_edge_t edge1_d = out1_auto_edge_sel ? auto_edge : man1_edge;

  // Register bank
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pwr_q <= DATA_W'(`CODS_RST_POWER_DOWN);
      edge_q <= DATA_W'(`CODS_RST_EDGE_RATE);
    end
    else
    begin
      pwr_q <= pwr_d;
      edge_q <= edge_d;
    end
  end

  // Read answer, one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= '0;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rdata_o <= req_i.rd ? rd_mux : '0;
      rvalid_o <= req_i.rd;
    end
  end

  // Driver controls are registered so glitches in the selection never reach the pads.
  // Reset state powers both drivers up with bypass edges, matching the register reset while cdr_i reports no lock.
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      line_out_zero_power_down_o <= 1'b0;
      line_out_one_power_down_o <= 1'b0;
      line_out_zero_edge_o <= CODS_EDGE_BYPASS;
      line_out_one_edge_o <= CODS_EDGE_BYPASS;
    end
    else
    begin
      line_out_zero_power_down_o <= pd0_d;
      line_out_one_power_down_o <= pd1_d;
      line_out_zero_edge_o <= edge0_d;
      line_out_one_edge_o <= edge1_d;
    end
  end

  // Checks
  default clocking chk_cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // A manual power-down write for output one reaches the pin two cycles later
  sequence s_wr_pd1_manual;
    req_i.wr && hit_pwr && !req_i.wdata[`CODS_PD_OUT1_AUTO_BIT];
  endsequence

  sequence s_pd1_follows;
    ##2 (line_out_one_power_down_o == $past(req_i.wdata[`CODS_PD_OUT1_MAN_BIT], 2));
  endsequence

  pd1_write_path_a: assert property (s_wr_pd1_manual |-> s_pd1_follows)
    else $error("output one power-down did not follow manual write");

  pd1_auto_sel_a: assert property ($past(out1_auto_power_down_sel)
    |-> line_out_one_power_down_o == $past(auto_power_down_req_i[1]))
    else $error("output one automatic power-down not followed");

  pd0_manual_a: assert property (!out0_auto_power_down_sel |=>
    line_out_zero_power_down_o == $past(out0_manual_power_down))
    else $error("output zero manual power-down not followed");

  pd0_auto_sel_a: assert property (out0_auto_power_down_sel && out0_manual_power_down
    && !auto_power_down_req_i[0] |=> !line_out_zero_power_down_o)
    else $error("output zero manual bit leaked through automatic mode");

  pd1_manual_ignored_a: assert property (out1_auto_power_down_sel && $stable(pwr_q)
    && $changed(auto_power_down_req_i[1]) |=> $changed(line_out_one_power_down_o))
    else $error("output one automatic power-down held by manual bit");

  edge1_manual_a: assert property (!out1_auto_edge_sel && out1_manual_edge_class != 2'h3
    |=> line_out_one_edge_o == cods_edge_t'($past(out1_manual_edge_class)))
    else $error("output one manual edge class not applied");

  edge1_auto_sel_a: assert property (out1_auto_edge_sel
    |=> line_out_one_edge_o == $past(auto_edge))
    else $error("output one automatic edge class not applied");

  edge0_manual_a: assert property (!out0_auto_edge_sel && out0_manual_edge_class != 2'h3
    |=> line_out_zero_edge_o == cods_edge_t'($past(out0_manual_edge_class)))
    else $error("output zero manual edge class not applied");

  edge0_auto_sel_a: assert property (out0_auto_edge_sel && !cdr_i.locked
    |=> line_out_zero_edge_o == CODS_EDGE_BYPASS)
    else $error("output zero automatic edge ignored unlock");

  auto_rate_map_a: assert property (out0_auto_edge_sel && cdr_i.locked
    && cdr_i.rate inside {CODS_RATE_1G485, CODS_RATE_2G97} |=> line_out_zero_edge_o == CODS_EDGE_HD)
    else $error("locked high rate did not give HD edge class");

  unlock_bypass_a: assert property ((out1_auto_edge_sel && !cdr_i.locked)[*2]
    |-> line_out_one_edge_o == CODS_EDGE_BYPASS)
    else $error("unlocked loop did not give bypass edge class");

  undef_code_a: assert property (!out1_auto_edge_sel && out1_manual_edge_class == 2'h3
    |=> line_out_one_edge_o == CODS_EDGE_BYPASS)
    else $error("manual code 3 not folded to bypass");

  // Read answers come one cycle after the strobe and only then; the decoder relies on zero data otherwise
  sequence s_read_req;
    req_i.rd;
  endsequence

  read_answer_a: assert property (s_read_req |=> rvalid_o && (rdata_o == $past(rd_mux)))
    else $error("read answer missing or wrong");

  read_quiet_a: assert property (!req_i.rd |=> !rvalid_o)
    else $error("read answer without a read strobe");

  rdata_idle_a: assert property (!rvalid_o |-> rdata_o == '0)
    else $error("read data not zero outside an answer");

  edge_defined_a: assert property (line_out_zero_edge_o != CODS_EDGE_UNDEF
    && line_out_one_edge_o != CODS_EDGE_UNDEF)
    else $error("undefined edge class reached a driver");

endmodule : cods_top

`default_nettype wire

// ### shared/cods_cfg.svh
/*
  Offsets, field positions, reset values and register-port widths for the
  cable output power-down and edge-rate control bank.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef CODS_CFG_SVH
`define CODS_CFG_SVH

// Register-port widths
`define CODS_ADDR_W 8
`define CODS_DATA_W 16

// Register offsets on the serial control port
`define CODS_OFS_POWER_DOWN 8'h4a
`define CODS_OFS_EDGE_RATE 8'h4b

// Reset values: power-down all zero, edge-rate auto on with bypass in the manual fields
`define CODS_RST_POWER_DOWN 16'h0000
`define CODS_RST_EDGE_RATE 16'h0505

// Power-down register fields
`define CODS_PD_OUT0_AUTO_BIT 0
`define CODS_PD_OUT0_MAN_BIT 1
`define CODS_PD_OUT1_AUTO_BIT 2
`define CODS_PD_OUT1_MAN_BIT 3

// Edge-rate register fields
`define CODS_ER_OUT0_AUTO_BIT 0
`define CODS_ER_OUT0_MAN_LSB 1
`define CODS_ER_OUT1_AUTO_BIT 8
`define CODS_ER_OUT1_MAN_LSB 9

`endif

// ### shared/cods_pkg.sv
/*
  Types for the cable output power-down and edge-rate control bank.
  Assumes cods_cfg.svh is on the include path.
*/
`default_nettype none
`include "cods_cfg.svh"

package cods_pkg;

  // Edge class applied to a cable driver
  typedef enum logic [1:0] {
    CODS_EDGE_SD = 2'h0,
    CODS_EDGE_HD = 2'h1,
    CODS_EDGE_BYPASS = 2'h2,
    CODS_EDGE_UNDEF = 2'h3
  } cods_edge_t;

  // Rate the clock-data-recovery loop reports when locked
  typedef enum logic [1:0] {
    CODS_RATE_125M = 2'h0,
    CODS_RATE_270M = 2'h1,
    CODS_RATE_1G485 = 2'h2,
    CODS_RATE_2G97 = 2'h3
  } cods_rate_t;

  // One access from the serial control port decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`CODS_ADDR_W-1:0] addr;
    logic [`CODS_DATA_W-1:0] wdata;
  } cods_req_t;

  // Status of the clock-data-recovery loop
  typedef struct packed {
    logic locked;
    cods_rate_t rate;
  } cods_cdr_t;

endpackage : cods_pkg

`default_nettype wire

// ### testbench/tb_top.sv
/*
  Self-checking bench for the cable output power-down and edge-rate bank.
  Assumes cods_pkg is compiled first and the design asserts its own rules.
*/
`default_nettype none

module tb_top
  import cods_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic core_clk_i = 1'b0;
  logic rst_b_i;
  cods_req_t req_i;
  cods_cdr_t cdr_i;
  logic [1:0] apd;
  logic [15:0] rdata_o;
  logic rvalid_o;
  logic pd0, pd1;
  cods_edge_t e0, e1;
  int n_errors = 0;
  int compares = 0;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'hc31f;
  logic [31:0] w;
  logic [15:0] d;

  // 40 MHz core clock
  always #12.5 core_clk_i = ~core_clk_i;

  cods_top DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .cdr_i(cdr_i), .auto_power_down_req_i(apd), .line_out_zero_power_down_o(pd0),
    .line_out_one_power_down_o(pd1), .line_out_zero_edge_o(e0), .line_out_one_edge_o(e1));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Locked rate to edge class, and manual field to class with the spare code parked on bypass
  function automatic cods_edge_t rcls(input logic [1:0] r);
    return r[1] ? CODS_EDGE_HD : CODS_EDGE_SD;
  endfunction : rcls

  function automatic cods_edge_t mcls(input logic [1:0] m);
    return (m == 2'h3) ? CODS_EDGE_BYPASS : cods_edge_t'(m);
  endfunction : mcls

  task automatic step();
    @(posedge core_clk_i);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_out(input logic p0, input logic p1, input cods_edge_t x0, input cods_edge_t x1);
    chk(16'({pd1, pd0}), 16'({p1, p0}), "power down");
    chk(16'(e0), 16'(x0), "edge zero");
    chk(16'(e1), 16'(x1), "edge one");
  endtask : chk_out

  // One register access; the caller releases the port, so back-to-back calls hold it busy
  task automatic acc(input logic wr, input logic rd, input logic [7:0] a, input logic [15:0] dv,
    input logic [15:0] e);
    req_i = {wr, rd, a, dv};
    if (rd)
      exp_q.push_back(e);
    step();
  endtask : acc

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Read data is checked against the oldest note when it appears
  always @(posedge core_clk_i)
    if (rvalid_o === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        n_errors++;
        $display("wrong value at %0t: read data with nothing expected", $time);
      end
      else
        chk(rdata_o, exp_q.pop_front(), "read data");
    end

  initial
  begin
    rst_b_i = 1'b0;
    req_i = '0;
    cdr_i = '0;
    apd = 2'h0;
    repeat (10) @(posedge core_clk_i);
    #1;
    rst_b_i = 1'b1;
    // Reset contents, then an unmapped write that must leave no trace
    acc(1'b0, 1'b1, 8'h4a, 16'h0, 16'h0000);
    acc(1'b0, 1'b1, 8'h4b, 16'h0, 16'h0505);
    acc(1'b1, 1'b0, 8'h4c, 16'hffff, 16'h0);
    acc(1'b0, 1'b1, 8'h4c, 16'h0, 16'h0000);
    req_i = '0;
    step();
    chk_out(1'b0, 1'b0, CODS_EDGE_BYPASS, CODS_EDGE_BYPASS);
    $display("test reset values done");
    // Automatic edge class across every locked rate, then loss of lock
    for (int r = 0; r < 4; r++)
    begin
      cdr_i = {1'b1, 2'(r)};
      step();
      step();
      chk_out(1'b0, 1'b0, rcls(2'(r)), rcls(2'(r)));
    end
    cdr_i.locked = 1'b0;
    step();
    step();
    chk_out(1'b0, 1'b0, CODS_EDGE_BYPASS, CODS_EDGE_BYPASS);
    $display("test automatic edge done");
    // Manual fields, spare code included, while a locked rate is offered and ignored
    for (int v = 0; v < 4; v++)
    begin
      w = rnd();
      cdr_i = {1'b1, w[1:0]};
      d = {5'h0, 2'(v), 1'b0, 5'h0, 2'(3 - v), 1'b0};
      acc(1'b1, 1'b0, 8'h4b, d, 16'h0);
      acc(1'b0, 1'b1, 8'h4b, 16'h0, d);
      req_i = '0;
      step();
      chk_out(1'b0, 1'b0, mcls(2'(3 - v)), mcls(2'(v)));
    end
    // Mixed: output zero automatic, output one manual at HD
    cdr_i = {1'b1, 2'h0};
    acc(1'b1, 1'b0, 8'h4b, 16'h0201, 16'h0);
    req_i = '0;
    step();
    step();
    chk_out(1'b0, 1'b0, CODS_EDGE_SD, CODS_EDGE_HD);
    $display("test manual edge done");
    // Every power-down setting against random automatic requests
    for (int v = 0; v < 16; v++)
    begin
      w = rnd();
      apd = w[1:0];
      acc(1'b1, 1'b0, 8'h4a, 16'(v), 16'h0);
      acc(1'b0, 1'b1, 8'h4a, 16'h0, 16'(v));
      req_i = '0;
      for (int k = 0; k < 2; k++)
      begin
        step();
        chk_out(v[0] ? apd[0] : v[1], v[2] ? apd[1] : v[3], CODS_EDGE_SD, CODS_EDGE_HD);
        apd = ~apd;
        step();
      end
    end
    $display("test power down done");
    // Reset in mid-run restores both registers; drivers fall back at once, without a clock
    rst_b_i = 1'b0;
    #1;
    chk_out(1'b0, 1'b0, CODS_EDGE_BYPASS, CODS_EDGE_BYPASS);
    step();
    rst_b_i = 1'b1;
    acc(1'b0, 1'b1, 8'h4a, 16'h0, 16'h0000);
    acc(1'b0, 1'b1, 8'h4b, 16'h0, 16'h0505);
    req_i = '0;
    for (int i = 0; i < 10 && exp_q.size() > 0; i++)
      step();
    if (exp_q.size() > 0)
    begin
      n_errors++;
      $display("wrong value at %0t: read answers missing", $time);
    end
    chk_out(1'b0, 1'b0, CODS_EDGE_SD, CODS_EDGE_SD);
    $display("test second reset done");
    give_verdict();
  end

endmodule : tb_top

`default_nettype wire
